// ===== tic_pkg.sv
// package: register map, field layout and constants of the time interval counter
package tic_pkg;
  // special-function addresses
  localparam logic [7:0] TIC_ADDR_CTRL = 8'ha1;
  localparam logic [7:0] TIC_ADDR_HSEC = 8'ha2;
  localparam logic [7:0] TIC_ADDR_SEC = 8'ha3;
  localparam logic [7:0] TIC_ADDR_MIN = 8'ha4;
  localparam logic [7:0] TIC_ADDR_HOUR = 8'ha5;
  localparam logic [7:0] TIC_ADDR_IVAL = 8'ha6;
  // control register reset value and field positions
  localparam logic [7:0] TIC_CTRL_RESET = 8'h00;
  localparam int TIC_BIT_HR24 = 6;
  localparam int TIC_BIT_TBH = 5;
  localparam int TIC_BIT_TBL = 4;
  localparam int TIC_BIT_SSHOT = 3;
  localparam int TIC_BIT_FLAG = 2;
  localparam int TIC_BIT_IVEN = 1;
  localparam int TIC_BIT_TMEN = 0;
  // counter limits
  localparam logic [7:0] TIC_HSEC_MAX = 8'h7f;
  localparam logic [7:0] TIC_SEC_MAX = 8'h3b;
  localparam logic [7:0] TIC_MIN_MAX = 8'h3b;
  localparam logic [7:0] TIC_HOUR_MAX_24 = 8'h17;
  localparam logic [7:0] TIC_HOUR_MAX_255 = 8'hff;
  localparam logic [7:0] TIC_ZERO = 8'h00;
  // timebase selections
  localparam logic [1:0] TIC_TB_128TH = 2'h0;
  localparam logic [1:0] TIC_TB_SEC = 2'h1;
  localparam logic [1:0] TIC_TB_MIN = 2'h2;
  localparam logic [1:0] TIC_TB_HOUR = 2'h3;
  // crystal edges per 1/128 second and interrupt vector
  localparam int TIC_XTAL_DIV = 256;
  localparam logic [15:0] TIC_VECTOR = 16'h0053;
  // special-function register write request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } tic_sfr_req_type;
endpackage

// ===== tic_timer.sv
// time interval counter: crystal-timed clock counters, interval compare and wake request
// Functional notes
// - counters are timed by the crystal oscillator, so they run through power-down.
// - timeout spans from 1/128 second up to 255 hours.
// - each step of the selected time counter advances the interval counter once.
// - interval count equal to compare value sets timeout flag in control bit 2.
// - timeout flag requests interrupt only while the interrupt enable bit is set.
// - in power-down with interrupt enabled, flag wakes device to vector 0053H.
// - software may preload time counters; counting continues from loaded values.
// - control register at A1H, resets to 00H, bit 7 reserved.
// - with wrap select set, hour counts 0 to 23 then wraps.
// - with wrap select clear, hour counts 0 to 255 then wraps.
// - device reset neither stops nor clears the time counters.
// - reset clears wrap select; software sets it again for 24-hour mode.
// - timebase select 00 1/128 s, 01 seconds, 10 minutes, 11 hours.
// - single-interval clears interval enable on timeout; otherwise counter reloads.
`timescale 1ns/10ps
module tic_timer #(
  parameter int XTAL_DIV = tic_pkg::TIC_XTAL_DIV
) (
  // clock and resets
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic por_n,
  // crystal oscillator pin
  input wire logic xtal_clk,
  // special-function register port
  input wire tic_pkg::tic_sfr_req_type sfr_req,
  output logic [7:0] sfr_rdata,
  // interrupt system
  input wire logic interval_irq_enable,
  input wire logic power_down,
  output logic irq_req,
  output logic wake_req,
  output logic [15:0] irq_vector
);
  import tic_pkg::*;

  logic xt_s1_ff, xt_s2_ff, xt_s3_ff;
  logic [$clog2(XTAL_DIV)-1:0] div_ff;
  logic tick_ff;
  logic [7:0] hsec_ff, sec_ff, min_ff, hour_ff, ival_ff, icnt_ff;
  logic [7:0] nxt_icnt;
  logic hr24_ff, sshot_ff, flag_ff, iven_ff, tmen_ff;
  logic [1:0] tbsel_ff;
  logic rst_any_n, run, ov_hsec, ov_sec, ov_min, tb_evt, timeout;
  logic [7:0] hour_max;

  // count up to the given top value, then back to zero
  function automatic logic [7:0] wrap_inc(input logic [7:0] v, input logic [7:0] top);
    return (v == top) ? TIC_ZERO : v + 8'h01;
  endfunction

  // write strobe for one address
  function automatic logic wr_hit(input tic_sfr_req_type r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // either reset clears the wrap select, read data and interrupt requests and reloads the vector; only power-on clears the rest
  assign rst_any_n = resetn & por_n;

  ////////////////////////////////////////////////////////////////////////////
  // crystal sampling and 1/128 s prescaler

  // crystal pin through two flops before any edge detect
  always_ff @(posedge clk_sys or negedge por_n) begin
    if (!por_n) begin
      xt_s1_ff <= 1'b0;
      xt_s2_ff <= 1'b0;
      xt_s3_ff <= 1'b0;
    end else begin
      xt_s1_ff <= xtal_clk;
      xt_s2_ff <= xt_s1_ff;
      xt_s3_ff <= xt_s2_ff;
    end
  end

  // divides crystal edges down to 128 Hz; only power-on resets it
  always_ff @(posedge clk_sys or negedge por_n) begin
    if (!por_n) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (xt_s2_ff && !xt_s3_ff) begin
        if (div_ff == $bits(div_ff)'(XTAL_DIV - 1)) begin
          div_ff <= '0;
          tick_ff <= 1'b1;
        end else begin
          div_ff <= div_ff + 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time counters

  assign run = tick_ff && tmen_ff;
  assign ov_hsec = run && (hsec_ff == TIC_HSEC_MAX);
  assign ov_sec = ov_hsec && (sec_ff == TIC_SEC_MAX);
  assign ov_min = ov_sec && (min_ff == TIC_MIN_MAX);
  assign hour_max = hr24_ff ? TIC_HOUR_MAX_24 : TIC_HOUR_MAX_255;

  // no device reset here, so time survives a core reset; a write wins over a tick
  always_ff @(posedge clk_sys or negedge por_n) begin
    if (!por_n) begin
      hsec_ff <= TIC_ZERO;
      sec_ff <= TIC_ZERO;
      min_ff <= TIC_ZERO;
      hour_ff <= TIC_ZERO;
    end else begin
      if (wr_hit(sfr_req, TIC_ADDR_HSEC)) hsec_ff <= sfr_req.wdata & TIC_HSEC_MAX;
      else if (run) hsec_ff <= wrap_inc(hsec_ff, TIC_HSEC_MAX);
      if (wr_hit(sfr_req, TIC_ADDR_SEC)) sec_ff <= sfr_req.wdata;
      else if (ov_hsec) sec_ff <= wrap_inc(sec_ff, TIC_SEC_MAX);
      if (wr_hit(sfr_req, TIC_ADDR_MIN)) min_ff <= sfr_req.wdata;
      else if (ov_sec) min_ff <= wrap_inc(min_ff, TIC_MIN_MAX);
      if (wr_hit(sfr_req, TIC_ADDR_HOUR)) hour_ff <= sfr_req.wdata;
      else if (ov_min) hour_ff <= wrap_inc(hour_ff, hour_max);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interval counter and compare

  // a step of the selected counter (a tick, or overflow of the counter below it) is the interval step
  always_comb begin
    case (tbsel_ff)
      TIC_TB_128TH: tb_evt = run;
      TIC_TB_SEC: tb_evt = ov_hsec;
      TIC_TB_MIN: tb_evt = ov_sec;
      TIC_TB_HOUR: tb_evt = ov_min;
      default: tb_evt = 1'b0;
    endcase
  end

  assign nxt_icnt = icnt_ff + 8'h01;
  // 8-bit count of hour steps gives the 255 hour span
  assign timeout = tb_evt && iven_ff && (nxt_icnt == ival_ff);

  // compare value write restarts the interval count
  always_ff @(posedge clk_sys or negedge por_n) begin
    if (!por_n) begin
      ival_ff <= TIC_ZERO;
      icnt_ff <= TIC_ZERO;
    end else begin
      if (wr_hit(sfr_req, TIC_ADDR_IVAL)) begin
        ival_ff <= sfr_req.wdata;
        icnt_ff <= TIC_ZERO;
      end else if (timeout) begin
        icnt_ff <= TIC_ZERO;
      end else if (tb_evt && iven_ff) begin
        icnt_ff <= nxt_icnt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  // wrap select falls back on any reset; hardware set of the flag beats a clear
  always_ff @(posedge clk_sys or negedge rst_any_n) begin
    if (!rst_any_n) begin
      hr24_ff <= TIC_CTRL_RESET[TIC_BIT_HR24];
    end else if (wr_hit(sfr_req, TIC_ADDR_CTRL)) begin
      hr24_ff <= sfr_req.wdata[TIC_BIT_HR24];
    end
  end

  always_ff @(posedge clk_sys or negedge por_n) begin
    if (!por_n) begin
      tbsel_ff <= TIC_CTRL_RESET[TIC_BIT_TBH:TIC_BIT_TBL];
      sshot_ff <= TIC_CTRL_RESET[TIC_BIT_SSHOT];
      flag_ff <= TIC_CTRL_RESET[TIC_BIT_FLAG];
      iven_ff <= TIC_CTRL_RESET[TIC_BIT_IVEN];
      tmen_ff <= TIC_CTRL_RESET[TIC_BIT_TMEN];
    end else begin
      if (wr_hit(sfr_req, TIC_ADDR_CTRL)) begin
        tbsel_ff <= sfr_req.wdata[TIC_BIT_TBH:TIC_BIT_TBL];
        sshot_ff <= sfr_req.wdata[TIC_BIT_SSHOT];
        flag_ff <= sfr_req.wdata[TIC_BIT_FLAG] || timeout;
        iven_ff <= sfr_req.wdata[TIC_BIT_IVEN] && !(timeout && sshot_ff);
        tmen_ff <= sfr_req.wdata[TIC_BIT_TMEN];
      end else if (timeout) begin
        flag_ff <= 1'b1;
        if (sshot_ff) iven_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and interrupt outputs

  // read mux registered; reserved bit 7 reads zero
  always_ff @(posedge clk_sys or negedge rst_any_n) begin
    if (!rst_any_n) begin
      sfr_rdata <= TIC_ZERO;
    end else begin
      case (sfr_req.addr)
        TIC_ADDR_CTRL: sfr_rdata <= {1'b0, hr24_ff, tbsel_ff, sshot_ff,
                                     flag_ff, iven_ff, tmen_ff};
        TIC_ADDR_HSEC: sfr_rdata <= hsec_ff;
        TIC_ADDR_SEC: sfr_rdata <= sec_ff;
        TIC_ADDR_MIN: sfr_rdata <= min_ff;
        TIC_ADDR_HOUR: sfr_rdata <= hour_ff;
        TIC_ADDR_IVAL: sfr_rdata <= ival_ff;
        default: sfr_rdata <= TIC_ZERO;
      endcase
    end
  end

  // wake runs on the always-on clock so it reaches a sleeping core
  always_ff @(posedge clk_sys or negedge rst_any_n) begin
    if (!rst_any_n) begin
      irq_req <= 1'b0;
      wake_req <= 1'b0;
      irq_vector <= TIC_VECTOR;
    end else begin
      irq_req <= flag_ff && interval_irq_enable;
      wake_req <= flag_ff && interval_irq_enable && power_down;
      irq_vector <= TIC_VECTOR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_any_n);

  chk_flag_on_match: assert property (timeout |=> flag_ff)
    else $error("timeout flag not set on compare match");
  chk_irq_gate: assert property (##1 irq_req == $past(flag_ff && interval_irq_enable))
    else $error("interrupt request not gated by enable");
  chk_wake_req: assert property (
    flag_ff && interval_irq_enable && power_down |=> wake_req && irq_vector == TIC_VECTOR)
    else $error("no wake request in power-down");
  chk_hour_wrap24: assert property (
    hr24_ff && hour_ff == TIC_HOUR_MAX_24 && ov_min && !wr_hit(sfr_req, TIC_ADDR_HOUR)
    |=> hour_ff == TIC_ZERO)
    else $error("hour did not wrap after 23");
  chk_hour_past23: assert property (
    !hr24_ff && hour_ff == TIC_HOUR_MAX_24 && ov_min && !wr_hit(sfr_req, TIC_ADDR_HOUR)
    |=> hour_ff == TIC_HOUR_MAX_24 + 8'h01)
    else $error("hour wrapped early in 255 mode");
  chk_single_shot: assert property (timeout && sshot_ff |=> !iven_ff)
    else $error("single interval did not clear enable");
  // reload keeps the enable; a control write that cycle may legally change it
  chk_auto_reload: assert property (
    timeout && !sshot_ff && !sfr_req.wr |=> icnt_ff == TIC_ZERO && iven_ff)
    else $error("interval counter not reloaded");
  chk_time_hold: assert property (!tmen_ff && !sfr_req.wr |=> $stable(hsec_ff))
    else $error("time counter moved while disabled");
  chk_wrap_reset: assert property ($rose(rst_any_n) |-> !hr24_ff)
    else $error("wrap select not cleared by reset");
  chk_step_once: assert property (
    tb_evt && iven_ff && !timeout && !sfr_req.wr |=> icnt_ff == $past(icnt_ff) + 8'h01)
    else $error("interval counter did not step by one");

  cov_timeout: cover property (timeout ##[1:4] irq_req);
  cov_wake: cover property (power_down ##1 wake_req);
  cov_day_wrap: cover property (hr24_ff && ov_min && hour_ff == TIC_HOUR_MAX_24);
  cov_reload: cover property (timeout && !sshot_ff);
endmodule

// ===== test_tic_timer.sv
// self-checking testbench of the time interval counter
`timescale 1ns/10ps
module test_tic_timer;
  import tic_pkg::*;
  logic clk_sys = 0, resetn = 0, por_n = 0, xtal_clk = 0;
  logic interval_irq_enable = 0, power_down = 0, irq_req, wake_req, f;
  tic_sfr_req_type sfr_req = '0;
  logic [7:0] sfr_rdata, v, h;
  logic [15:0] irq_vector;
  int n_mismatch = 0, total_checks = 0, seed = 66, i;
  ////////////////////////////////////////////////////////////////////////
  // small divider keeps a 1/128 tick near 8 core cycles
  tic_timer #(.XTAL_DIV(2)) dut (.clk_sys(clk_sys), .resetn(resetn), .por_n(por_n),
    .xtal_clk(xtal_clk), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .interval_irq_enable(interval_irq_enable), .power_down(power_down),
    .irq_req(irq_req), .wake_req(wake_req), .irq_vector(irq_vector));
  // core clock, and a free-running crystal at one quarter of its rate
  initial forever #10 clk_sys = ~clk_sys;
  initial forever begin
    repeat (2) @(negedge clk_sys);
    xtal_clk <= ~xtal_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task summarize;
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(string name, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", name, e, g);
    end
  endtask
  task chk_bit(string name, logic e, logic g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %b got %b", name, e, g);
    end
  endtask
  // one-cycle write strobe, launched off the sampling edge
  task wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk_sys);
    sfr_req = '{addr: a, wdata: d, wr: 1'b1};
    @(negedge clk_sys);
    sfr_req.wr = 1'b0;
  endtask
  // read data is registered, so it is taken one edge after the address
  task rd(logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    sfr_req.addr = a;
    @(negedge clk_sys);
    d = sfr_rdata;
  endtask
  // a bound ran out: count it and go straight to the verdict
  task give_up;
    n_mismatch++;
    summarize();
  endtask
  // waits for the 1/128 counter to move, bounded
  task wait_tick;
    logic [7:0] a, b;
    rd(TIC_ADDR_HSEC, a);
    for (i = 0; i < 100; i++) begin
      rd(TIC_ADDR_HSEC, b);
      if (b !== a) break;
    end
    if (i == 100) give_up();
    repeat (3) @(negedge clk_sys);
  endtask
  task load(logic [7:0] hs, logic [7:0] s, logic [7:0] m);
    wr(TIC_ADDR_CTRL, 8'h00);
    wr(TIC_ADDR_HSEC, hs);
    wr(TIC_ADDR_SEC, s);
    wr(TIC_ADDR_MIN, m);
  endtask
  function logic [7:0] exp_ctrl(logic [1:0] tb, logic fired);
    return {2'b00, tb, 1'b1, fired, ~fired, 1'b1};
  endfunction
  function logic [7:0] hour_after(logic day_hour_wrap_select, logic [7:0] hr);
    if (day_hour_wrap_select && hr == TIC_HOUR_MAX_24) return TIC_ZERO;
    return hr + 8'h01;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk_sys);
    por_n = 1;
    resetn = 1;
    rd(TIC_ADDR_CTRL, v);
    chk("ctrl_reset", TIC_CTRL_RESET, v);
    wr(TIC_ADDR_CTRL, 8'hf8);
    rd(TIC_ADDR_CTRL, v);
    chk("ctrl_reserved", 8'h78, v);
    rd(8'ha7, v);
    chk("unmapped", 8'h00, v);
    chk("vector", 16'h0053, irq_vector);
    // hour wrap in both modes, from preloaded time
    for (int k = 0; k < 3; k++) begin
      h = (k == 2) ? 8'hff : 8'h17;
      load(TIC_HSEC_MAX, TIC_SEC_MAX, TIC_MIN_MAX);
      wr(TIC_ADDR_HOUR, h);
      wr(TIC_ADDR_CTRL, (k == 0) ? 8'h41 : 8'h01);
      wait_tick();
      rd(TIC_ADDR_HOUR, v);
      chk("hour", hour_after(k == 0, h), v);
      rd(TIC_ADDR_MIN, v);
      chk("minute", 8'h00, v);
    end
    // each timebase against each overflow depth, single-interval mode
    for (int tb = 0; tb < 4; tb++) begin
      for (int d = 0; d < 4; d++) begin
        interval_irq_enable = 1'($random(seed));
        power_down = 1'($random(seed));
        load((d >= 1) ? TIC_HSEC_MAX : 8'h00, (d >= 2) ? TIC_SEC_MAX : 8'h00,
             (d >= 3) ? TIC_MIN_MAX : 8'h00);
        wr(TIC_ADDR_IVAL, 8'h01);
        wr(TIC_ADDR_CTRL, {2'b00, 2'(tb), 4'b1011});
        wait_tick();
        f = (tb <= d);
        rd(TIC_ADDR_CTRL, v);
        chk("ctrl_interval", exp_ctrl(2'(tb), f), v);
        chk_bit("irq_req", f & interval_irq_enable, irq_req);
        chk_bit("wake_req", f & interval_irq_enable & power_down, wake_req);
      end
    end
    // reload mode: flag after exactly three ticks, enable kept
    load(8'h00, 8'h00, 8'h00);
    wr(TIC_ADDR_IVAL, 8'h03);
    wr(TIC_ADDR_CTRL, 8'h03);
    for (i = 0; i < 200; i++) begin
      rd(TIC_ADDR_CTRL, v);
      if (v[TIC_BIT_FLAG] === 1'b1) break;
    end
    if (i == 200) give_up();
    rd(TIC_ADDR_HSEC, h);
    chk("ticks_to_flag", 8'h03, h);
    chk("ctrl_reload", 8'h07, v);
    // device reset keeps time running but drops 24-hour mode
    load(8'h40, 8'h00, 8'h00);
    wr(TIC_ADDR_HOUR, 8'h05);
    wr(TIC_ADDR_CTRL, 8'h41);
    resetn = 0;
    repeat (2) @(negedge clk_sys);
    resetn = 1;
    rd(TIC_ADDR_CTRL, v);
    chk("ctrl_after_reset", 8'h01, v);
    rd(TIC_ADDR_HOUR, v);
    chk("hour_kept", 8'h05, v);
    rd(TIC_ADDR_HSEC, v);
    chk_bit("hsec_kept", 1'b1, v >= 8'h40);
    summarize();
  end
endmodule
